// [src/tksc_map.vh]
// Command codes, reset values and timing figures for the touch key setup handler.
// Included by the command handler; holds definitions only.
`ifndef TKSC_MAP_VH
`define TKSC_MAP_VH

// ==========================================
// Clock
`define TKSC_CLK_KHZ 10000

// ==========================================
// Command codes
`define TKSC_CMD_GET 8'h67
`define TKSC_CMD_PUT 8'h70
`define TKSC_CMD_PSPACE 8'h0D
`define TKSC_CMD_BAND_POS 8'h0E
`define TKSC_CMD_BAND_NEG 8'h0F
`define TKSC_CMD_AKS 8'h10
`define TKSC_CMD_CSUM 8'h36
`define TKSC_CMD_LOCK 8'h4C
`define TKSC_CMD_RECAL 8'h62
`define TKSC_CMD_LAST 8'h6C
`define TKSC_CMD_RESET 8'h72
`define TKSC_NULL 8'h00

// ==========================================
// Operand limits and reset values
`define TKSC_PSPACE_MIN 8'h01
`define TKSC_PSPACE_MAX 8'h0A
`define TKSC_PSPACE_RST 8'h01
`define TKSC_BAND_RST 8'h00
`define TKSC_AKS_OFF 8'h00
`define TKSC_AKS_ON 8'h01
`define TKSC_LAST_RST 8'h00

// ==========================================
// Timing
`define TKSC_GAP_MS 100
`define TKSC_RST_DLY_MS 16
`define TKSC_PERMIL 28'h00003E8

`endif

// [src/tksc_link_rx.v]
// Byte link slave: samples the host clock, select and data with the local clock.
// Assumes the link clock is far slower than clk (at least four clk periods per half).
`timescale 1ns/1ps

module tksc_link_rx (
  input wire clk, // Local clock
  input wire rst_n, // Synchronised reset, active low
  input wire sclk, // Link clock from host
  input wire ss_n, // Frame select from host, active low
  input wire mosi, // Data from host
  output wire miso_o, // Data to host
  output wire miso_oe_n, // Drive enable for data to host, active low
  output reg rx_valid_ff, // One-cycle pulse, byte received
  output reg [7:0] rx_byte_ff, // Received byte
  input wire tx_load, // Pulse, queue a reply byte
  input wire [7:0] tx_byte // Reply byte
);

  // ==========================================
  // Input synchronisers
  reg [1:0] sclk_sync_ff;
  reg [1:0] ss_sync_ff;
  reg [1:0] mosi_sync_ff;
  reg sclk_d_ff;
  reg [2:0] bit_cnt_ff;
  reg [7:0] shin_ff;
  reg [7:0] shout_ff;
  wire sclk_rise;
  wire sclk_fall;
  wire sel;

  assign sel = ~ss_sync_ff[1];
  assign sclk_rise = sclk_sync_ff[1] & ~sclk_d_ff;
  assign sclk_fall = ~sclk_sync_ff[1] & sclk_d_ff;
  assign miso_o = shout_ff[7];
  assign miso_oe_n = ~sel;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_ff <= 2'h0;
      ss_sync_ff <= 2'h3;
      mosi_sync_ff <= 2'h0;
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[0], sclk};
      ss_sync_ff <= {ss_sync_ff[0], ss_n};
      mosi_sync_ff <= {mosi_sync_ff[0], mosi};
      sclk_d_ff <= sclk_sync_ff[1];
    end
  end

  // ==========================================
  // Shift registers, MSB first, sample on rising, shift out on falling
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_ff <= 3'h0;
      shin_ff <= 8'h00;
      shout_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
    end else begin
      rx_valid_ff <= 1'b0;
      if (!sel) begin
        bit_cnt_ff <= 3'h0;
      end else if (sclk_rise) begin
        shin_ff <= {shin_ff[6:0], mosi_sync_ff[1]};
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (bit_cnt_ff == 3'h7) begin
          rx_valid_ff <= 1'b1;
          rx_byte_ff <= {shin_ff[6:0], mosi_sync_ff[1]};
        end
      end
      // A queued reply wins over shifting so it is never half lost.
      // The fall after the eighth rise is skipped: a reply queued for the
      // next frame would otherwise lose its top bit before it is sent.
      if (tx_load) begin
        shout_ff <= tx_byte;
      end else if (sel && sclk_fall && bit_cnt_ff != 3'h0) begin
        shout_ff <= {shout_ff[6:0], 1'b0};
      end
    end
  end

endmodule // tksc_link_rx

// [src/tksc_cmd.v]
// Setup and supervisory command handler of a 16-key touch matrix controller.
// Assumes the host link is a byte link with a slow clock; sensing logic supplies
// references, deltas and pending detections on the same clock.
`timescale 1ns/1ps
`include "tksc_map.vh"

module tksc_cmd #(
  parameter GAP_CYC = `TKSC_GAP_MS * `TKSC_CLK_KHZ, // Second byte window
  parameter RST_DLY_CYC = `TKSC_RST_DLY_MS * `TKSC_CLK_KHZ // Echo to hard reset
) (
  input wire clk, // 10 MHz clock
  input wire resetn, // Asynchronous reset, active low
  input wire sclk, // Link clock from host
  input wire ss_n, // Link select from host, active low
  input wire mosi, // Link data from host
  output wire miso_o, // Link data to host
  output wire miso_oe_n, // Link data drive enable, active low
  input wire [15:0] scope_mask, // Keys in current scope
  input wire [3:0] scope_low_key, // Lowest ranked key in scope
  input wire [255:0] key_ref, // Current reference per key, 16 bits each
  input wire [127:0] key_delta, // Negative signal delta per key, 8 bits each
  input wire [15:0] key_pending, // Pending detection per key
  input wire [15:0] key_burst_zero, // Key burst length is zero
  input wire [7:0] nv_checksum, // Nonvolatile memory checksum
  input wire nv_write_done, // Pulse, nonvolatile lock write finished
  output reg nv_write_start_ff, // Pulse, start nonvolatile lock write
  output reg [255:0] locked_ref_ff, // Locked references to store
  output reg [7:0] pulse_space_ff, // Intra-burst pulse spacing, microseconds
  output reg [7:0] band_pos_ff, // Positive error band, tenths of percent
  output reg [7:0] band_neg_ff, // Negative error band, tenths of percent
  output reg [15:0] aks_en_ff, // Adjacent key suppression enable per key
  output reg [15:0] key_err_ff, // Reference error flag per key
  output reg [15:0] key_detect_ff, // Declared detection per key
  output reg [15:0] recal_start_ff, // Pulse, (re)start recalibration per key
  output reg get_dir_ff, // High in get direction
  output reg hard_reset_ff // Pulse, hard reset request
);

  // ==========================================
  // Reset release
  reg [1:0] rst_sync_ff;
  wire rst_n;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ==========================================
  // Link
  wire rx_valid;
  wire [7:0] rx_byte;
  reg tx_load_ff;
  reg [7:0] tx_byte_ff;

  tksc_link_rx u_link (
    .clk(clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .ss_n(ss_n),
    .mosi(mosi),
    .miso_o(miso_o),
    .miso_oe_n(miso_oe_n),
    .rx_valid_ff(rx_valid),
    .rx_byte_ff(rx_byte),
    .tx_load(tx_load_ff),
    .tx_byte(tx_byte_ff)
  );

  // ==========================================
  // Command sequencer
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_OPND = 4'b0010;
  localparam [3:0] ST_NVWR = 4'b0100;
  localparam [3:0] ST_RSTW = 4'b1000;

  reg [3:0] state_ff;
  reg [7:0] cmd_ff;
  reg [7:0] last_cmd_ff;
  reg [19:0] timer_ff;
  reg lock_valid_ff;
  wire gap_over;
  wire rst_due;
  wire aks_low;

  assign gap_over = (timer_ff == GAP_CYC[19:0] - 20'h1);
  assign rst_due = (timer_ff == RST_DLY_CYC[19:0] - 20'h1);
  assign aks_low = aks_en_ff[scope_low_key];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cmd_ff <= 8'h00;
      last_cmd_ff <= `TKSC_LAST_RST;
      timer_ff <= 20'h0;
      get_dir_ff <= 1'b1;
      pulse_space_ff <= `TKSC_PSPACE_RST;
      band_pos_ff <= `TKSC_BAND_RST;
      band_neg_ff <= `TKSC_BAND_RST;
      aks_en_ff <= 16'h0000;
      tx_load_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
      recal_start_ff <= 16'h0000;
      nv_write_start_ff <= 1'b0;
      locked_ref_ff <= 256'h0;
      lock_valid_ff <= 1'b0;
      hard_reset_ff <= 1'b0;
    end else begin
      tx_load_ff <= 1'b0;
      recal_start_ff <= 16'h0000;
      nv_write_start_ff <= 1'b0;
      hard_reset_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          timer_ff <= 20'h0;
          if (rx_valid) begin
            cmd_ff <= rx_byte;
            case (rx_byte)
              `TKSC_CMD_GET, `TKSC_CMD_PUT: begin
                get_dir_ff <= (rx_byte == `TKSC_CMD_GET);
                tx_byte_ff <= rx_byte;
                tx_load_ff <= 1'b1;
                last_cmd_ff <= rx_byte;
              end
              `TKSC_CMD_PSPACE, `TKSC_CMD_BAND_POS, `TKSC_CMD_BAND_NEG, `TKSC_CMD_AKS: begin
                if (get_dir_ff) begin
                  case (rx_byte)
                    `TKSC_CMD_PSPACE: tx_byte_ff <= pulse_space_ff;
                    `TKSC_CMD_BAND_POS: tx_byte_ff <= band_pos_ff;
                    `TKSC_CMD_BAND_NEG: tx_byte_ff <= band_neg_ff;
                    default: tx_byte_ff <= {7'h00, aks_low};
                  endcase
                  tx_load_ff <= 1'b1;
                  last_cmd_ff <= rx_byte;
                end else begin
                  state_ff <= ST_OPND;
                end
              end
              `TKSC_CMD_CSUM, `TKSC_CMD_LAST: begin
                // Put direction makes these invalid: no reply, not recorded
                if (get_dir_ff) begin
                  tx_byte_ff <= (rx_byte == `TKSC_CMD_CSUM) ? nv_checksum
                                                            : last_cmd_ff;
                  tx_load_ff <= 1'b1;
                  last_cmd_ff <= rx_byte;
                end
              end
              `TKSC_CMD_LOCK, `TKSC_CMD_RESET: begin
                if (!get_dir_ff) begin
                  state_ff <= ST_OPND;
                end
              end
              `TKSC_CMD_RECAL: begin
                if (!get_dir_ff) begin
                  recal_start_ff <= scope_mask;
                  tx_byte_ff <= rx_byte;
                  tx_load_ff <= 1'b1;
                  last_cmd_ff <= rx_byte;
                end
              end
              default: begin
              end
            endcase
          end
        end
        ST_OPND: begin
          timer_ff <= timer_ff + 20'h1;
          if (rx_valid) begin
            state_ff <= ST_IDLE;
            tx_byte_ff <= cmd_ff;
            case (cmd_ff)
              `TKSC_CMD_PSPACE: begin
                if (rx_byte >= `TKSC_PSPACE_MIN && rx_byte <= `TKSC_PSPACE_MAX) begin
                  pulse_space_ff <= rx_byte;
                  tx_load_ff <= 1'b1;
                  last_cmd_ff <= cmd_ff;
                end
              end
              `TKSC_CMD_BAND_POS: begin
                band_pos_ff <= rx_byte;
                tx_load_ff <= 1'b1;
                last_cmd_ff <= cmd_ff;
              end
              `TKSC_CMD_BAND_NEG: begin
                band_neg_ff <= rx_byte;
                tx_load_ff <= 1'b1;
                last_cmd_ff <= cmd_ff;
              end
              `TKSC_CMD_AKS: begin
                if (rx_byte == `TKSC_AKS_OFF || rx_byte == `TKSC_AKS_ON) begin
                  aks_en_ff <= rx_byte[0] ? (aks_en_ff | scope_mask)
                                          : (aks_en_ff & ~scope_mask);
                  tx_load_ff <= 1'b1;
                  last_cmd_ff <= cmd_ff;
                end
              end
              `TKSC_CMD_LOCK: begin
                if (rx_byte == `TKSC_NULL) begin
                  locked_ref_ff <= key_ref;
                  lock_valid_ff <= 1'b0;
                  nv_write_start_ff <= 1'b1;
                  state_ff <= ST_NVWR;
                end
              end
              `TKSC_CMD_RESET: begin
                if (rx_byte == `TKSC_NULL) begin
                  tx_load_ff <= 1'b1;
                  last_cmd_ff <= cmd_ff;
                  state_ff <= ST_RSTW;
                  timer_ff <= 20'h0;
                end
              end
              default: begin
              end
            endcase
          end else if (gap_over) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_NVWR: begin
          if (nv_write_done) begin
            lock_valid_ff <= 1'b1;
            tx_byte_ff <= `TKSC_CMD_LOCK;
            tx_load_ff <= 1'b1;
            last_cmd_ff <= `TKSC_CMD_LOCK;
            state_ff <= ST_IDLE;
          end
        end
        ST_RSTW: begin
          timer_ff <= timer_ff + 20'h1;
          if (rst_due) begin
            hard_reset_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Per-key boundary check and suppression
  wire [15:0] err_nxt;
  wire [15:0] det_nxt;
  wire [27:0] pos_mul;
  wire [27:0] neg_mul;

  assign pos_mul = `TKSC_PERMIL + {20'h0, band_pos_ff};
  assign neg_mul = `TKSC_PERMIL - {20'h0, band_neg_ff};

  genvar gi;
  genvar gj;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_key
      wire [27:0] ref_s;
      wire [27:0] hi_s;
      wire [27:0] lo_s;
      wire [15:0] bigger;
      wire pos_err;
      wire neg_err;
      // Scaled by a thousand so tenths of a percent compare exactly
      assign ref_s = {12'h0, key_ref[16*gi +: 16]} * `TKSC_PERMIL;
      assign hi_s = {12'h0, locked_ref_ff[16*gi +: 16]} * pos_mul;
      assign lo_s = {12'h0, locked_ref_ff[16*gi +: 16]} * neg_mul;
      assign pos_err = (band_pos_ff != 8'h00) && (ref_s > hi_s);
      assign neg_err = (band_neg_ff != 8'h00) && (ref_s < lo_s);
      assign err_nxt[gi] = lock_valid_ff & (pos_err | neg_err);
      for (gj = 0; gj < 16; gj = gj + 1) begin : g_cmp
        if (gj == gi) begin : g_self
          assign bigger[gj] = 1'b0;
        end else begin : g_other
          assign bigger[gj] = ~key_burst_zero[gj] &
            (key_delta[8*gj +: 8] > key_delta[8*gi +: 8]);
        end
      end
      assign det_nxt[gi] = key_pending[gi] &
        (key_detect_ff[gi] | ~aks_en_ff[gi] | ~(|bigger));
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_err_ff <= 16'h0000;
      key_detect_ff <= 16'h0000;
    end else begin
      key_err_ff <= err_nxt;
      key_detect_ff <= det_nxt;
    end
  end

endmodule // tksc_cmd

// [verification/tksc_chk.sv]
// Checker for the touch key setup handler, watching the top ports only.
// Assumes it is bound to tksc_cmd; everything runs on clk.
`timescale 1ns/1ps

module tksc_chk (
  input wire clk, // Clock
  input wire resetn, // Reset, active low
  input wire ss_n, // Link select
  input wire miso_oe_n, // Reply drive enable
  input wire [15:0] scope_mask, // Keys in scope
  input wire [255:0] key_ref, // References
  input wire [15:0] key_pending, // Pending detections
  input wire nv_write_start_ff, // Lock write start
  input wire [255:0] locked_ref_ff, // Locked references
  input wire [7:0] pulse_space_ff, // Pulse spacing
  input wire [7:0] band_pos_ff, // Positive band
  input wire [7:0] band_neg_ff, // Negative band
  input wire [15:0] aks_en_ff, // Suppression enables
  input wire [15:0] key_err_ff, // Error flags
  input wire [15:0] key_detect_ff, // Detections
  input wire [15:0] recal_start_ff, // Recalibration starts
  input wire hard_reset_ff // Hard reset request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ====
  // Setup and supervisory
  a_pspace_range: assert property (pulse_space_ff >= 8'h01 && pulse_space_ff <= 8'h0A)
    else $error("pulse spacing out of range");
  a_band_off: assert property (band_pos_ff == 8'h00 && band_neg_ff == 8'h00 |=> key_err_ff == 16'h0000)
    else $error("error flag with both bands off");
  a_recal_scope: assert property (|recal_start_ff |-> recal_start_ff == $past(scope_mask))
    else $error("recalibration not on scoped keys");
  a_recal_pulse: assert property (|recal_start_ff |=> recal_start_ff == 16'h0000)
    else $error("recalibration start longer than one cycle");
  a_lock_copy: assert property (nv_write_start_ff |-> locked_ref_ff == $past(key_ref))
    else $error("locked references differ from references");
  a_lock_pulse: assert property (nv_write_start_ff |=> !nv_write_start_ff)
    else $error("lock write start longer than one cycle");
  a_hreset_pulse: assert property ($rose(hard_reset_ff) |=> !hard_reset_ff)
    else $error("hard reset request longer than one cycle");
  // Link reply drive follows select after the two-stage synchroniser
  a_drive_on: assert property ((!ss_n) [*4] |-> !miso_oe_n)
    else $error("reply line not driven in frame");
  a_drive_off: assert property (ss_n [*4] |-> miso_oe_n)
    else $error("reply line driven outside frame");

  // ====
  // Key detection
  a_detect_pend: assert property ((key_detect_ff & ~$past(key_pending)) == 16'h0000)
    else $error("detection without pending key");
  a_detect_free: assert property (((key_detect_ff ^ $past(key_pending)) & ~$past(aks_en_ff)) == 16'h0000)
    else $error("unsuppressed key detection wrong");
  a_detect_keep: assert property (##1 ((~key_detect_ff & $past(key_detect_ff & key_pending)) == 16'h0000))
    else $error("held detection dropped");
endmodule // tksc_chk

// [verification/tksc_host.sv]
// Host model: sends link frames, MSB first, and collects the reply bits.
// Assumes its task is called at a falling edge of the 100 ns clock.
`timescale 1ns/1ps

module tksc_host (
  output reg sclk, // Link clock, still outside frames
  output reg ss_n, // Frame select, active low
  output reg mosi, // Data to device
  input wire miso_o, // Data from device
  input wire miso_oe_n // Device drives data when low
);
  reg prev_v;

  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
    prev_v = 1'b0;
  end

  // ====
  // One byte frame, 800 ns per bit
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      ss_n = 1'b0;
      for (i = 7; i >= 0; i = i - 1) begin
        mosi = tx[i];
        #400;
        // Undriven line reads as the inverse of the last bit seen
        prev_v = miso_oe_n ? ~prev_v : miso_o;
        rx[i] = prev_v;
        sclk = 1'b1;
        #400;
        sclk = 1'b0;
      end
      #400;
      ss_n = 1'b1;
      mosi = ~tx[0];
      #1600;
    end
  endtask
endmodule // tksc_host

// [verification/testbench.sv]
// Testbench for the touch key setup handler; the host model drives the link.
// Assumes design, checker and host model are compiled before this file.
`timescale 1ns/1ps

module testbench;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [15:0] scope_mask = 16'h00F0;
  reg [3:0] scope_low_key = 4'h4;
  reg [255:0] key_ref = {16{16'h03E8}};
  reg [127:0] key_delta = 128'h0;
  reg [15:0] key_pending = 16'h0000;
  reg [15:0] key_burst_zero = 16'h0000;
  reg nv_write_done = 1'b0;
  wire sclk, ss_n, mosi, miso_o, miso_oe_n, nv_write_start_ff, get_dir_ff, hard_reset_ff;
  wire [255:0] locked_ref_ff;
  wire [7:0] pulse_space_ff, band_pos_ff, band_neg_ff;
  wire [15:0] aks_en_ff, key_err_ff, key_detect_ff, recal_start_ff;
  reg [7:0] rx;
  reg [15:0] recal_or = 16'h0000;
  integer errors = 0, samples_checked = 0, cyc = 0, starts = 0, recals = 0;
  integer hr_cyc = 0, lh = 0, i;
  localparam [39:0] PS_OP = {8'h00, 8'h01, 8'h0A, 8'h0B, 8'h05};
  localparam [39:0] PS_EXP = {8'h01, 8'h01, 8'h0A, 8'h0A, 8'h05};

  always #50 clk = ~clk;

  tksc_cmd #(.GAP_CYC(200), .RST_DLY_CYC(50)) uut (.clk(clk), .resetn(resetn), .sclk(sclk),
    .ss_n(ss_n), .mosi(mosi), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
    .scope_mask(scope_mask), .scope_low_key(scope_low_key), .key_ref(key_ref),
    .key_delta(key_delta), .key_pending(key_pending), .key_burst_zero(key_burst_zero),
    .nv_checksum(8'hA5), .nv_write_done(nv_write_done), .nv_write_start_ff(nv_write_start_ff),
    .locked_ref_ff(locked_ref_ff), .pulse_space_ff(pulse_space_ff), .band_pos_ff(band_pos_ff),
    .band_neg_ff(band_neg_ff), .aks_en_ff(aks_en_ff), .key_err_ff(key_err_ff),
    .key_detect_ff(key_detect_ff), .recal_start_ff(recal_start_ff), .get_dir_ff(get_dir_ff),
    .hard_reset_ff(hard_reset_ff));

  tksc_host host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso_o(miso_o),
    .miso_oe_n(miso_oe_n));

  // ====
  // Monitors and nonvolatile write stand-in
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sclk)
      lh <= cyc;
    if (nv_write_start_ff)
      starts <= starts + 1;
    if (|recal_start_ff) begin
      recals <= recals + 1;
      recal_or <= recal_or | recal_start_ff;
    end
    if (hard_reset_ff)
      hr_cyc <= cyc;
  end

  always @(negedge clk) begin
    if (nv_write_start_ff) begin
      repeat (30) @(negedge clk);
      nv_write_done <= 1'b1;
      @(negedge clk);
      nv_write_done <= 1'b0;
    end
  end

  // ====
  // Tasks
  task chk(input string name, input [255:0] exp, input [255:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task send(input [7:0] b);
    host.xfer(b, rx);
  endtask

  // Command and operand, then a null frame that carries the echo back
  task put2(input [7:0] c, input [7:0] o);
    begin
      send(c);
      send(o);
      send(8'h00);
    end
  endtask

  task getr(input [7:0] c);
    begin
      send(c);
      send(8'h00);
    end
  endtask

  task print_verdict;
    begin
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  initial begin
    #3000000;
    errors = errors + 1;
    print_verdict;
  end

  // ====
  // Tests
  initial begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    chk("direction", 1, get_dir_ff);
    chk("bands", 16'h0000, {band_pos_ff, band_neg_ff});
    getr(8'h0D);
    chk("spacing get", 8'h01, rx);
    getr(8'h6C);
    chk("last cmd", 8'h0D, rx);
    getr(8'h6C);
    chk("last repeat", 8'h6C, rx);
    send(8'h70);
    chk("direction", 0, get_dir_ff);
    for (i = 4; i >= 0; i = i - 1) begin
      put2(8'h0D, PS_OP[8*i+:8]);
      chk("spacing", PS_EXP[8*i+:8], pulse_space_ff);
    end
    chk("spacing echo", 8'h0D, rx);
    put2(8'h0E, 8'hFF);
    chk("band pos", 8'hFF, band_pos_ff);
    put2(8'h0F, 8'h14);
    chk("band neg", 8'h14, band_neg_ff);
    chk("no lock no err", 16'h0000, key_err_ff);
    put2(8'h10, 8'h01);
    chk("aks echo", 8'h10, rx);
    put2(8'h10, 8'h02);
    chk("aks bad op", 16'h00F0, aks_en_ff);
    scope_mask = 16'h0080;
    scope_low_key = 4'h7;
    put2(8'h10, 8'h00);
    chk("aks off", 16'h0070, aks_en_ff);
    send(8'h62);
    getr(8'h62);
    chk("recal echo", 8'h62, rx);
    chk("recal count", 2, recals);
    chk("recal keys", 16'h0080, recal_or);
    send(8'h4C);
    repeat (300) @(negedge clk);
    send(8'h00);
    chk("late lock", 0, starts);
    send(8'h4C);
    send(8'h00);
    repeat (60) @(negedge clk);
    send(8'h00);
    chk("lock echo", 8'h4C, rx);
    chk("lock starts", 1, starts);
    chk("locked refs", {16{16'h03E8}}, locked_ref_ff);
    put2(8'h0E, 8'h32);
    key_ref[31:0] = {16'h03CA, 16'h0424};
    repeat (3) @(negedge clk);
    chk("key errors", 16'h0003, key_err_ff);
    put2(8'h0E, 8'h00);
    chk("pos band off", 16'h0002, key_err_ff);
    put2(8'h0F, 8'h00);
    chk("neg band off", 16'h0000, key_err_ff);
    put2(8'h0F, 8'h14);
    key_delta[79:32] = {8'h28, 8'h00, 8'h00, 8'h00, 8'h14, 8'h0A};
    key_burst_zero = 16'h0200;
    key_pending = 16'h0030;
    repeat (3) @(negedge clk);
    chk("suppress", 16'h0020, key_detect_ff);
    key_burst_zero = 16'h0000;
    key_delta[79:72] = 8'h32;
    repeat (3) @(negedge clk);
    chk("detect held", 16'h0020, key_detect_ff);
    scope_mask = 16'h0070;
    scope_low_key = 4'h4;
    send(8'h67);
    getr(8'h0F);
    chk("band get", 8'h14, rx);
    getr(8'h10);
    chk("aks get", 8'h01, rx);
    getr(8'h36);
    chk("checksum", 8'hA5, rx);
    send(8'h70);
    send(8'h72);
    send(8'h00);
    i = lh;
    send(8'h00);
    chk("reset echo", 8'h72, rx);
    chk("reset delay", 1, hr_cyc - i >= 44 && hr_cyc - i <= 58);
    print_verdict;
  end
endmodule // testbench

bind tksc_cmd tksc_chk u_chk (.clk(clk), .resetn(resetn), .ss_n(ss_n), .miso_oe_n(miso_oe_n),
  .scope_mask(scope_mask), .key_ref(key_ref), .key_pending(key_pending),
  .nv_write_start_ff(nv_write_start_ff), .locked_ref_ff(locked_ref_ff),
  .pulse_space_ff(pulse_space_ff), .band_pos_ff(band_pos_ff), .band_neg_ff(band_neg_ff),
  .aks_en_ff(aks_en_ff), .key_err_ff(key_err_ff), .key_detect_ff(key_detect_ff),
  .recal_start_ff(recal_start_ff), .hard_reset_ff(hard_reset_ff));
